// [rtl/event_flag_pkg.sv]
//
// Behaviour
// - request parity flag bit 0, needs enable
// - check request data from every source
// - only transmitter-bound data is checked
// - host write parity mismatch sets flag
// - write to read-only register sets reject
package event_flag_pkg;
	// ****************************************
	// register map
	// ****************************************
	localparam logic [4:0] NOISE_EVENT_COUNT_OFS   = 5'h07;
	localparam logic [4:0] RECEIVE_STATE_OFS       = 5'h08;
	localparam logic [4:0] NOISE_PRESCALE_OFS      = 5'h10;
	localparam logic [4:0] LINE_STATE_COUNT_OFS    = 5'h13;
	localparam logic [4:0] LINE_STATE_PRESCALE_OFS = 5'h14;
	localparam logic [4:0] LINK_ERROR_COUNT_OFS    = 5'h16;
	localparam logic [4:0] DEVICE_IDENTITY_OFS     = 5'h18;
	localparam logic [4:0] INJECTION_COUNT_OFS     = 5'h19;
	localparam logic [4:0] EVENT_FLAGS_OFS         = 5'h02;
	localparam logic [4:0] TRANSMIT_STATE_OFS      = 5'h04;
	// ****************************************
	// field positions and resets
	// ****************************************
	localparam int         REQ_PARITY_BIT    = 0;
	localparam int         HOST_PARITY_BIT   = 1;
	localparam int         WRITE_REJECT_BIT  = 2;
	localparam int         CHECK_ENABLE_BIT  = 0;
	localparam logic [7:0] FLAGS_RESET       = 8'h00;
	localparam logic [7:0] TRANSMIT_RESET    = 8'h00;
	localparam logic [7:0] IDENTITY_VALUE    = 8'h5a; // arbitrary value
	// ****************************************
	// carriers
	// ****************************************
	typedef enum logic [1:0] {SRC_INVALID, SRC_RECEIVE, SRC_SWITCH_A, SRC_SWITCH_B} source_t;
	typedef struct packed {
		logic       write;   // write strobe
		logic       read;    // read strobe
		logic [4:0] addr;    // register index
		logic [7:0] data;    // host_bus_data_lines
		logic       parity;  // host_bus_parity_line
	} host_req_t;
	typedef struct packed {
		logic [7:0] data;    // request data byte
		logic       parity;  // its parity bit
	} req_word_t;
endpackage : event_flag_pkg

// [rtl/request_parity_check.sv]
`timescale 1ns/1ps
// ****************************************
// transmitter-side parity check
// ****************************************
module request_parity_check (
	// clock
	input  wire logic                      clk,
	input  wire logic                      rst_n,
	input  wire logic                      ce,
	// source buses
	input  wire event_flag_pkg::req_word_t src_word [4],
	input  wire event_flag_pkg::source_t   src_sel,
	input  wire logic                      tx_take,
	// result
	output logic                           parity_err
);
	event_flag_pkg::req_word_t sel_word; // word entering transmitter

	// pick the selected source, any of the four
	always_comb begin
		sel_word = src_word[src_sel];
	end

	// registered error, only when the transmitter takes the word
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			parity_err <= 1'b0;
		end else if (ce) begin
			// odd parity over data plus parity bit; bypass traffic ignored
			parity_err <= tx_take && !(^{sel_word.data, sel_word.parity});
		end
	end
endmodule : request_parity_check

// [rtl/event_condition_flag_logic.sv]
`timescale 1ns/1ps
// ****************************************
// event condition flags and host register access
// ****************************************
// only the three error flags live here; the other condition
// bits, their mask and the interrupt line belong elsewhere
module event_condition_flag_logic (
	// clock and reset
	input  wire logic                      clk,
	input  wire logic                      rst_n,
	input  wire logic                      ce,
	// host control bus, already on this clock
	input  wire event_flag_pkg::host_req_t host_req,
	output logic [7:0]                     host_rdata,
	// request data into the transmitter
	input  wire event_flag_pkg::req_word_t src_word [4],
	input  wire event_flag_pkg::source_t   src_sel,
	input  wire logic                      tx_take,
	// state from other blocks, shown read-only
	input  wire logic [7:0]                ro_values [7],
	// flag view
	output logic [7:0]                     flags_out
);
	// ****************************************
	// storage
	// ****************************************
	logic [7:0] flags_reg;     // condition flags
	logic [7:0] transmit_reg;  // transmit_state_register
	logic       req_err;       // parity error from checker
	logic       host_par_bad;  // write parity mismatch
	logic       ro_hit;        // write to read-only index
	logic [7:0] set_vec;       // hardware sets this cycle
	logic [7:0] clr_vec;       // software clears this cycle

	// read-only index decode for the reject flag
	function automatic logic is_read_only(input logic [4:0] a);
		case (a)
			event_flag_pkg::NOISE_EVENT_COUNT_OFS,
			event_flag_pkg::RECEIVE_STATE_OFS,
			event_flag_pkg::NOISE_PRESCALE_OFS,
			event_flag_pkg::LINE_STATE_COUNT_OFS,
			event_flag_pkg::LINE_STATE_PRESCALE_OFS,
			event_flag_pkg::LINK_ERROR_COUNT_OFS,
			event_flag_pkg::DEVICE_IDENTITY_OFS,
			event_flag_pkg::INJECTION_COUNT_OFS: is_read_only = 1'b1;
			default: is_read_only = 1'b0;
		endcase
	endfunction : is_read_only

	// ****************************************
	// request parity checker
	// ****************************************
	request_parity_check u_check (
		.clk        (clk),
		.rst_n      (rst_n),
		.ce         (ce),
		.src_word   (src_word),
		.src_sel    (src_sel),
		.tx_take    (tx_take),
		.parity_err (req_err)
	);

	// ****************************************
	// event decode
	// ****************************************
	always_comb begin
		// odd parity expected across data and parity line
		host_par_bad = host_req.write && !(^{host_req.data, host_req.parity});
		ro_hit       = host_req.write && is_read_only(host_req.addr);
		set_vec      = 8'h00;
		// only when the enable bit is on
		set_vec[event_flag_pkg::REQ_PARITY_BIT] = req_err &&
			transmit_reg[event_flag_pkg::CHECK_ENABLE_BIT];
		set_vec[event_flag_pkg::HOST_PARITY_BIT]  = host_par_bad;
		set_vec[event_flag_pkg::WRITE_REJECT_BIT] = ro_hit;
		// writing a 1 clears; a bad-parity write clears nothing
		clr_vec = 8'h00;
		if (host_req.write && !host_par_bad &&
			host_req.addr == event_flag_pkg::EVENT_FLAGS_OFS) begin
			clr_vec = host_req.data;
		end
	end

	// ****************************************
	// sticky flags, set beats clear
	// ****************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			flags_reg <= event_flag_pkg::FLAGS_RESET;
		end else if (ce) begin
			flags_reg <= (flags_reg & ~clr_vec) | set_vec;
		end
	end

	// ****************************************
	// transmit state register, holds enable
	// ****************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			transmit_reg <= event_flag_pkg::TRANSMIT_RESET;
		end else if (ce && host_req.write && !host_par_bad &&
			host_req.addr == event_flag_pkg::TRANSMIT_STATE_OFS) begin
			// corrupt data is not trusted to change the enable
			transmit_reg <= host_req.data;
		end
	end

	// ****************************************
	// read data, registered
	// ****************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			host_rdata <= 8'h00;
		end else if (ce && host_req.read) begin
			case (host_req.addr)
				event_flag_pkg::EVENT_FLAGS_OFS:         host_rdata <= flags_reg;
				event_flag_pkg::TRANSMIT_STATE_OFS:      host_rdata <= transmit_reg;
				event_flag_pkg::NOISE_EVENT_COUNT_OFS:   host_rdata <= ro_values[0];
				event_flag_pkg::RECEIVE_STATE_OFS:       host_rdata <= ro_values[1];
				event_flag_pkg::NOISE_PRESCALE_OFS:      host_rdata <= ro_values[2];
				event_flag_pkg::LINE_STATE_COUNT_OFS:    host_rdata <= ro_values[3];
				event_flag_pkg::LINE_STATE_PRESCALE_OFS: host_rdata <= ro_values[4];
				event_flag_pkg::LINK_ERROR_COUNT_OFS:    host_rdata <= ro_values[5];
				event_flag_pkg::DEVICE_IDENTITY_OFS:     host_rdata <= event_flag_pkg::IDENTITY_VALUE;
				event_flag_pkg::INJECTION_COUNT_OFS:     host_rdata <= ro_values[6];
				default:                                 host_rdata <= 8'h00;
			endcase
		end
	end

	assign flags_out = flags_reg;

	// ****************************************
	// checks on the request parity path
	// ****************************************
	// a detected error with the enable on must land in the flag
	AST_REQ_SET: assert property (@(posedge clk) disable iff (!rst_n)
		ce && req_err && transmit_reg[event_flag_pkg::CHECK_ENABLE_BIT]
		|=> flags_reg[event_flag_pkg::REQ_PARITY_BIT])
		else $error("request parity flag not set");
	// with the enable off a clear flag stays clear
	AST_REQ_GATED: assert property (@(posedge clk) disable iff (!rst_n)
		ce && !flags_reg[event_flag_pkg::REQ_PARITY_BIT]
		&& !transmit_reg[event_flag_pkg::CHECK_ENABLE_BIT]
		|=> !flags_reg[event_flag_pkg::REQ_PARITY_BIT])
		else $error("request parity flag set while disabled");
	// the flag only rises through a checker error
	AST_REQ_ONLY_ERR: assert property (@(posedge clk) disable iff (!rst_n)
		ce && !flags_reg[event_flag_pkg::REQ_PARITY_BIT] && !req_err
		|=> !flags_reg[event_flag_pkg::REQ_PARITY_BIT])
		else $error("request parity flag set without an error");
	// bypass traffic never reaches the checker's register
	AST_NO_TAKE: assert property (@(posedge clk) disable iff (!rst_n)
		ce && !tx_take |=> !req_err)
		else $error("bypass data raised parity error");
	// a faulted word from whichever source is selected is caught
	AST_SRC_CHECK: assert property (@(posedge clk) disable iff (!rst_n)
		ce && tx_take && !(^{src_word[src_sel].data, src_word[src_sel].parity})
		|=> req_err)
		else $error("selected source parity missed");
	// a clean word taken by the transmitter raises nothing
	AST_SRC_CLEAN: assert property (@(posedge clk) disable iff (!rst_n)
		ce && tx_take && (^{src_word[src_sel].data, src_word[src_sel].parity})
		|=> !req_err)
		else $error("clean request word flagged");

	// ****************************************
	// checks on the host bus path
	// ****************************************
	// a write whose parity fails must raise the host parity flag
	AST_HOST_PAR: assert property (@(posedge clk) disable iff (!rst_n)
		ce && host_req.write && !(^{host_req.data, host_req.parity})
		|=> flags_reg[event_flag_pkg::HOST_PARITY_BIT])
		else $error("host parity flag not set");
	// reads and clean writes never raise it
	AST_HOST_QUIET: assert property (@(posedge clk) disable iff (!rst_n)
		ce && !flags_reg[event_flag_pkg::HOST_PARITY_BIT]
		&& !(host_req.write && !(^{host_req.data, host_req.parity}))
		|=> !flags_reg[event_flag_pkg::HOST_PARITY_BIT])
		else $error("host parity flag set without a fault");
	// corrupt write data must not reach the transmit state register
	AST_HOST_NO_STORE: assert property (@(posedge clk) disable iff (!rst_n)
		ce && host_req.write && !(^{host_req.data, host_req.parity})
		|=> $stable(transmit_reg))
		else $error("corrupt write stored");
	// a write to the identity index is refused
	AST_REJECT: assert property (@(posedge clk) disable iff (!rst_n)
		ce && host_req.write && host_req.addr == event_flag_pkg::DEVICE_IDENTITY_OFS
		|=> flags_reg[event_flag_pkg::WRITE_REJECT_BIT])
		else $error("read-only write not rejected");
	// every other read-only index is refused just the same
	AST_REJECT_ANY: assert property (@(posedge clk) disable iff (!rst_n)
		ce && host_req.write && (host_req.addr == event_flag_pkg::NOISE_EVENT_COUNT_OFS
		|| host_req.addr == event_flag_pkg::RECEIVE_STATE_OFS
		|| host_req.addr == event_flag_pkg::NOISE_PRESCALE_OFS
		|| host_req.addr == event_flag_pkg::LINE_STATE_COUNT_OFS
		|| host_req.addr == event_flag_pkg::LINE_STATE_PRESCALE_OFS
		|| host_req.addr == event_flag_pkg::LINK_ERROR_COUNT_OFS
		|| host_req.addr == event_flag_pkg::INJECTION_COUNT_OFS)
		|=> flags_reg[event_flag_pkg::WRITE_REJECT_BIT])
		else $error("read-only count write not rejected");
	// no write at all, no reject
	AST_NO_REJECT: assert property (@(posedge clk) disable iff (!rst_n)
		ce && !flags_reg[event_flag_pkg::WRITE_REJECT_BIT] && !host_req.write
		|=> !flags_reg[event_flag_pkg::WRITE_REJECT_BIT])
		else $error("reject flag set without write");
	// the two writable indices are never refused
	AST_WRITABLE: assert property (@(posedge clk) disable iff (!rst_n)
		ce && !flags_reg[event_flag_pkg::WRITE_REJECT_BIT]
		&& (host_req.addr == event_flag_pkg::EVENT_FLAGS_OFS
		|| host_req.addr == event_flag_pkg::TRANSMIT_STATE_OFS)
		|=> !flags_reg[event_flag_pkg::WRITE_REJECT_BIT])
		else $error("writable index rejected");
	// the identity reads back its fixed value
	AST_ID_READ: assert property (@(posedge clk) disable iff (!rst_n)
		ce && host_req.read && host_req.addr == event_flag_pkg::DEVICE_IDENTITY_OFS
		|=> host_rdata == event_flag_pkg::IDENTITY_VALUE)
		else $error("identity read wrong");

	// ****************************************
	// checks on retention and freeze
	// ****************************************
	// a raised host parity flag survives until a clear write
	AST_STICKY: assert property (@(posedge clk) disable iff (!rst_n)
		flags_reg[event_flag_pkg::HOST_PARITY_BIT]
		&& !(ce && host_req.write && host_req.addr == event_flag_pkg::EVENT_FLAGS_OFS)
		|=> flags_reg[event_flag_pkg::HOST_PARITY_BIT])
		else $error("flag dropped without clear");
	// so does a raised reject flag
	AST_STICKY_REJECT: assert property (@(posedge clk) disable iff (!rst_n)
		flags_reg[event_flag_pkg::WRITE_REJECT_BIT]
		&& !(ce && host_req.write && host_req.addr == event_flag_pkg::EVENT_FLAGS_OFS)
		|=> flags_reg[event_flag_pkg::WRITE_REJECT_BIT])
		else $error("reject flag dropped without clear");
	// and a raised request parity flag
	AST_STICKY_REQ: assert property (@(posedge clk) disable iff (!rst_n)
		flags_reg[event_flag_pkg::REQ_PARITY_BIT]
		&& !(ce && host_req.write && host_req.addr == event_flag_pkg::EVENT_FLAGS_OFS)
		|=> flags_reg[event_flag_pkg::REQ_PARITY_BIT])
		else $error("request flag dropped without clear");
	// a clean clear of the host parity bit takes effect next cycle
	AST_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
		ce && host_req.write && (^{host_req.data, host_req.parity})
		&& host_req.addr == event_flag_pkg::EVENT_FLAGS_OFS
		&& host_req.data[event_flag_pkg::HOST_PARITY_BIT]
		|=> !flags_reg[event_flag_pkg::HOST_PARITY_BIT])
		else $error("host parity flag not cleared");
	// nothing moves while the clock enable is low
	AST_CE_FREEZE: assert property (@(posedge clk) disable iff (!rst_n)
		!ce |=> $stable(flags_reg) && $stable(transmit_reg) && $stable(host_rdata)
		&& $stable(req_err))
		else $error("state moved with clock enable low");
endmodule : event_condition_flag_logic

// [test/host_bus_model.sv]
`timescale 1ns/1ps
// ****************************************
// host processor model on the control bus
// ****************************************
module host_bus_model (
	// clock
	input  wire logic                 clk,
	// request towards the device
	output event_flag_pkg::host_req_t host_req
);
	initial host_req = '0; // idle, no strobe
	// one access, launched off the falling edge, strobe high for one cycle
	task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] d, input logic bad);
		@(negedge clk);
		host_req.write  = w;
		host_req.read   = ~w;
		host_req.addr   = a;
		host_req.data   = d;
		host_req.parity = (~^d) ^ bad; // odd parity unless a fault is wanted
		@(negedge clk);
		// released lines show the inverse, never a stale copy
		host_req        = {2'b00, ~a, ~d, ~host_req.parity};
	endtask : acc
endmodule : host_bus_model

// [test/tb.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
	$display("[FAIL] %0t got %h want %h", $time, g, e); end end
module tb;
	// ****************************************
	// signals
	// ****************************************
	logic                      clk;
	logic                      rst_n;
	logic                      ce;
	logic                      tx_take;
	event_flag_pkg::host_req_t host_req;
	logic [7:0]                host_rdata;
	logic [7:0]                flags_out;
	event_flag_pkg::req_word_t src_word [4];
	event_flag_pkg::source_t   src_sel;
	logic [7:0]                ro_values [7];
	int                        err_count, num_checks, cycles;
	// rows: address, parity fault, expected flag view
	typedef struct {logic [4:0] a; logic bad; logic [7:0] f;} row_t;
	row_t rows [10] = '{'{5'h04, 1'b0, 8'h00}, '{5'h04, 1'b1, 8'h02}, '{5'h07, 1'b0, 8'h04},
		'{5'h08, 1'b0, 8'h04}, '{5'h10, 1'b0, 8'h04}, '{5'h13, 1'b0, 8'h04},
		'{5'h14, 1'b0, 8'h04}, '{5'h16, 1'b0, 8'h04}, '{5'h18, 1'b0, 8'h04},
		'{5'h19, 1'b0, 8'h04}};
	event_condition_flag_logic event_condition_flag_logic_inst (
		.clk(clk), .rst_n(rst_n), .ce(ce), .host_req(host_req), .host_rdata(host_rdata),
		.src_word(src_word), .src_sel(src_sel), .tx_take(tx_take), .ro_values(ro_values),
		.flags_out(flags_out));
	host_bus_model host_bus_model_inst (.clk(clk), .host_req(host_req));
	// ****************************************
	// clock and hang guard
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// generous ceiling, the run needs well under a thousand cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			err_count++;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : complete_run
	// clear all flags, then the view must read zero
	task automatic clr();
		host_bus_model_inst.acc(1'b1, 5'h02, 8'hff, 1'b0);
		@(negedge clk);
		`CHK(flags_out, 8'h00)
	endtask : clr
	// one request word with a parity fault, taken by the transmitter only when take is set
	task automatic send(input int s, input logic take);
		src_sel              = event_flag_pkg::source_t'(s);
		src_word[s].parity   = 1'b0;
		tx_take              = take;
		@(negedge clk);
		tx_take              = 1'b0;
		src_word[s].parity   = 1'b1;
		repeat (3) @(negedge clk);
	endtask : send
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		rst_n = 1'b0;
		ce = 1'b1;
		tx_take = 1'b0;
		src_sel = event_flag_pkg::SRC_INVALID;
		foreach (src_word[i]) src_word[i] = '{8'h00, 1'b1};
		foreach (ro_values[i]) ro_values[i] = 8'(8'h11 * i);
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		`CHK(flags_out, 8'h00)
		$display("reset test done");
		foreach (rows[i]) begin
			host_bus_model_inst.acc(1'b1, rows[i].a, 8'h00, rows[i].bad);
			@(negedge clk);
			`CHK(flags_out, rows[i].f)
			clr();
		end
		$display("table test done");
		// every source, with checking enabled
		host_bus_model_inst.acc(1'b1, 5'h04, 8'h01, 1'b0);
		for (int s = 0; s < 4; s++) begin
			send(s, 1'b1);
			`CHK(flags_out, 8'h01)
			host_bus_model_inst.acc(1'b0, 5'h02, 8'h00, 1'b0);
			repeat (4) @(negedge clk);
			`CHK(host_rdata, 8'h01)
			clr();
		end
		send(2, 1'b0);
		`CHK(flags_out, 8'h00)
		$display("source test done");
		// enable off, then a refused write, one idle cycle, then a rejected one
		host_bus_model_inst.acc(1'b1, 5'h04, 8'h00, 1'b0);
		send(1, 1'b1);
		`CHK(flags_out, 8'h00)
		host_bus_model_inst.acc(1'b1, 5'h04, 8'h01, 1'b1);
		host_bus_model_inst.acc(1'b1, 5'h18, 8'h00, 1'b0);
		@(negedge clk);
		`CHK(flags_out, 8'h06)
		host_bus_model_inst.acc(1'b0, 5'h04, 8'h00, 1'b0);
		@(negedge clk);
		`CHK(host_rdata, 8'h00)
		`CHK(flags_out, 8'h06)
		$display("refusal test done");
		// read side: a count, the identity, then an unmapped index
		host_bus_model_inst.acc(1'b0, 5'h19, 8'h00, 1'b0);
		`CHK(host_rdata, ro_values[6])
		host_bus_model_inst.acc(1'b0, 5'h18, 8'h00, 1'b0);
		`CHK(host_rdata, event_flag_pkg::IDENTITY_VALUE)
		host_bus_model_inst.acc(1'b0, 5'h1f, 8'h00, 1'b0);
		`CHK(host_rdata, 8'h00)
		$display("read test done");
		// clock enable low: a clean clear must not land
		ce = 1'b0;
		host_bus_model_inst.acc(1'b1, 5'h02, 8'hff, 1'b0);
		ce = 1'b1;
		@(negedge clk);
		`CHK(flags_out, 8'h06)
		$display("freeze test done");
		// a clear taken in the cycle of a fresh request error: the set wins
		host_bus_model_inst.acc(1'b1, 5'h04, 8'h01, 1'b0);
		fork
			send(0, 1'b1);
			host_bus_model_inst.acc(1'b1, 5'h02, 8'hff, 1'b0);
		join
		`CHK(flags_out, 8'h01)
		$display("collision test done");
		complete_run();
	end
endmodule : tb
